// ### mmt_cfg.svh
// register map, field positions and fixed values of the timer channel
`ifndef MMT_CFG_SVH
`define MMT_CFG_SVH

`define MMT_ADDR_W        12
`define MMT_ADDR_MODE     12'h000
`define MMT_ADDR_TIMER    12'h004
`define MMT_ADDR_CTRL     12'h008
`define MMT_ADDR_STATUS   12'h00C

`define MMT_RST_MODE      8'h00
`define MMT_RST_CNT       16'h0000
`define MMT_RST_CTRL      6'h00
`define MMT_RST_PRE       8'h00

`define MMT_MODE_OP_LO    0
`define MMT_MODE_OP_HI    1
`define MMT_MODE_FB0      2
`define MMT_MODE_FB1      3
`define MMT_MODE_FB2      4
`define MMT_MODE_FB3      5
`define MMT_MODE_CTS      6
`define MMT_MODE_QPS      7

`define MMT_CTRL_START    0
`define MMT_CTRL_OSHOT    1
`define MMT_CTRL_UPDN     2
`define MMT_CTRL_QEN      3
`define MMT_CTRL_TSEL_LO  4
`define MMT_CTRL_TSEL_HI  5
`define MMT_CTRL_MASK     6'h3D

`define MMT_CNT_MAX       16'hFFFF
`define MMT_CNT_ZERO      16'h0000
`define MMT_CNT_ONE       16'h0001
`define MMT_CYC16         16'hFFFF
`define MMT_CYC8          16'h00FF
`define MMT_PRE_ZERO      8'h00

`endif

// ### mmt_pkg.sv
// types shared by the timer channel
package mmt_pkg;
	typedef enum logic [1:0] {
		MMT_OP_TIMER,
		MMT_OP_EVENT,
		MMT_OP_ONESHOT,
		MMT_OP_PWM
	} mmt_op_t;

	typedef enum logic [1:0] {
		MMT_QK_NONE,
		MMT_QK_NORMAL,
		MMT_QK_SELECT,
		MMT_QK_X4
	} mmt_quad_t;

	typedef enum {
		MMT_PW_IDLE,
		MMT_PW_HIGH,
		MMT_PW_LOW
	} mmt_pwm_st_t;
endpackage

// ### mmt_channel.sv
// multi-mode 16-bit timer channel with apb register slave
// Notes on behaviour
// RQ1: single-phase always; two-phase only on quad channels
// RQ2: event source: pin edge or selected overflow
// RQ3: direction from software flag or output pin
// RQ4: reload type reloads on overflow/underflow
// RQ5: divide ratio FFFF-n+1 up, n+1 down
// RQ6: interrupt on every overflow or underflow
// RQ7: write stopped: reload and counter; running: reload
// RQ8: event counting runs while start flag set
// RQ9: free-run wraps without reloading
// RQ10: pulse output toggles on each wrap
// RQ11: normal two-phase: up rise, down fall
// RQ12: multiply-by-4 counts all edges, phase decides direction
// RQ13: processing type selectable on one channel only
// RQ14: software writes two-phase mode bits correctly
// RQ15: count type and processing bit meanings
// RQ16: software enables two-phase, trigger select 00
// RQ17: one-shot counts down, reloads, stops, interrupts
// RQ18: trigger during one-shot restarts the period
// RQ19: one-shot starts on trigger or flag, lasts n
// RQ20: pwm reloads at rise, ignores triggers, irq at fall
// RQ21: 16-bit pwm: n high in 65535
// RQ22: 8-bit pwm: prescale m+1, n of 255
// RQ23: trigger select 00 pin, others overflows
// RQ24: direction flag 0 down, 1 up
`include "mmt_cfg.svh"

module mmt_channel #(
	parameter mmt_pkg::mmt_quad_t QUAD_KIND = mmt_pkg::MMT_QK_NONE
) (
	input  wire logic                   core_clk,
	input  wire logic                   nrst,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`MMT_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   tick_f1,
	input  wire logic                   tick_f8,
	input  wire logic                   tick_f32,
	input  wire logic                   tick_subclock_div32,
	input  wire logic                   ovf_in_a,
	input  wire logic                   ovf_in_b,
	input  wire logic                   ovf_in_c,
	input  wire logic                   count_input_pin,
	input  wire logic                   pulse_output_pin_i,
	output logic                        pulse_output_pin_o,
	output logic                        pulse_output_pin_oe,
	output logic                        timer_irq,
	output logic                        timer_ovf
);
	import mmt_pkg::*;

	logic [7:0]  mode_q, mode_d;
	logic [15:0] reload_q, reload_d;
	logic [15:0] cnt_q, cnt_d;
	logic [5:0]  ctrl_q, ctrl_d;
	logic [7:0]  pre_q, pre_d;
	logic        out_q, out_d;
	logic        os_run_q, os_run_d;
	logic        irq_q, irq_d;
	logic        ovf_q, ovf_d;
	logic        pin_q, pin_d;
	logic        phb_q, phb_d;
	mmt_pwm_st_t pw_q, pw_d;

	mmt_op_t     op;
	logic        start, free_run, wr_en, wr_timer, wr_ctrl, quad_on, quad_x4;
	logic        pin_rise, pin_fall, phb_rise, phb_fall, ext_edge, sel_ovf, trig;
	logic        src_tick, ptick, ev_step, ev_up, ev_wrap, os_trig, pwm_8;
	logic [15:0] ev_next, hi_len, lo_len, cyc;

	function automatic logic ovf_pick(input logic [1:0] sel, input logic a, input logic b,
		input logic c, input logic pin);
		unique case (sel)
			2'h0: ovf_pick = pin;
			2'h1: ovf_pick = a;
			2'h2: ovf_pick = b;
			2'h3: ovf_pick = c;
		endcase
	endfunction

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !(paddr == `MMT_ADDR_MODE || paddr == `MMT_ADDR_TIMER
		|| paddr == `MMT_ADDR_CTRL || paddr == `MMT_ADDR_STATUS);
	assign pulse_output_pin_o = out_q;
	assign timer_irq          = irq_q;
	assign timer_ovf          = ovf_q;

	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			`MMT_ADDR_MODE:   prdata = {24'h00_0000, mode_q};
			`MMT_ADDR_TIMER:  prdata = {16'h0000, cnt_q};
			`MMT_ADDR_CTRL:   prdata = {26'h000_0000, ctrl_q & `MMT_CTRL_MASK};
			`MMT_ADDR_STATUS: prdata = {29'h0000_0000, pw_q != MMT_PW_IDLE, os_run_q, out_q};
			default:          prdata = 32'h0000_0000;
		endcase
	end

	always_comb begin
		op       = mmt_op_t'(mode_q[`MMT_MODE_OP_HI:`MMT_MODE_OP_LO]);
		start    = ctrl_q[`MMT_CTRL_START];
		free_run = mode_q[`MMT_MODE_CTS];                                    // [RQ15]
		pwm_8    = mode_q[`MMT_MODE_FB3];
		wr_en    = psel && penable && pwrite;
		wr_timer = wr_en && paddr == `MMT_ADDR_TIMER;
		wr_ctrl  = wr_en && paddr == `MMT_ADDR_CTRL;
		// two-phase only where the channel kind allows it
		quad_on  = QUAD_KIND != MMT_QK_NONE && ctrl_q[`MMT_CTRL_QEN]
			&& op == MMT_OP_EVENT;                                           // [RQ1]
		quad_x4  = QUAD_KIND == MMT_QK_X4
			|| (QUAD_KIND == MMT_QK_SELECT && mode_q[`MMT_MODE_QPS]);        // [RQ13] [RQ15]
		pin_rise = count_input_pin && !pin_q;
		pin_fall = !count_input_pin && pin_q;
		phb_rise = pulse_output_pin_i && !phb_q;
		phb_fall = !pulse_output_pin_i && phb_q;
		ext_edge = mode_q[`MMT_MODE_FB1] ? pin_rise : pin_fall;
		sel_ovf  = ovf_pick(ctrl_q[`MMT_CTRL_TSEL_HI:`MMT_CTRL_TSEL_LO],
			ovf_in_a, ovf_in_b, ovf_in_c, ext_edge);                         // [RQ23]
		trig     = mode_q[`MMT_MODE_FB2] && sel_ovf;
		unique case (mode_q[`MMT_MODE_QPS:`MMT_MODE_CTS])
			2'h0: src_tick = tick_f1;
			2'h1: src_tick = tick_f8;
			2'h2: src_tick = tick_f32;
			2'h3: src_tick = tick_subclock_div32;
		endcase

		if (quad_on && quad_x4) begin
			ev_step = pin_rise || pin_fall || phb_rise || phb_fall;         // [RQ12]
			ev_up   = (pin_rise && pulse_output_pin_i) || (pin_fall && !pulse_output_pin_i)
				|| (phb_rise && !count_input_pin) || (phb_fall && count_input_pin);
		end else if (quad_on) begin
			ev_step = pulse_output_pin_i && (pin_rise || pin_fall);         // [RQ11]
			ev_up   = pin_rise;
		end else begin
			ev_step = sel_ovf;                                               // [RQ2]
			ev_up   = mode_q[`MMT_MODE_FB2] ? pulse_output_pin_i
				: ctrl_q[`MMT_CTRL_UPDN];                                    // [RQ3] [RQ24]
		end
		ev_step = ev_step && start && op == MMT_OP_EVENT;                    // [RQ8]
		ev_wrap = ev_up ? cnt_q == `MMT_CNT_MAX : cnt_q == `MMT_CNT_ZERO;
		if (ev_wrap && !free_run) begin
			ev_next = reload_q;                                              // [RQ4] [RQ5]
		end else if (ev_up) begin
			ev_next = cnt_q + `MMT_CNT_ONE;                                  // [RQ9]
		end else begin
			ev_next = cnt_q - `MMT_CNT_ONE;
		end

		cyc     = pwm_8 ? `MMT_CYC8 : `MMT_CYC16;
		hi_len  = pwm_8 ? {8'h00, reload_q[15:8]} : reload_q;               // [RQ21] [RQ22]
		lo_len  = cyc - hi_len;
		ptick   = src_tick && (!pwm_8 || pre_q == `MMT_PRE_ZERO);           // [RQ22]
		os_trig = start && ((wr_ctrl && pwdata[`MMT_CTRL_OSHOT]) || trig);  // [RQ19]

		mode_d   = mode_q;
		reload_d = reload_q;
		cnt_d    = cnt_q;
		ctrl_d   = ctrl_q;
		pre_d    = pre_q;
		out_d    = out_q;
		os_run_d = os_run_q;
		pw_d     = pw_q;
		irq_d    = 1'b0;
		ovf_d    = 1'b0;
		pin_d    = count_input_pin;
		phb_d    = pulse_output_pin_i;
		pulse_output_pin_oe = 1'b0;

		if (wr_en && paddr == `MMT_ADDR_MODE) begin
			mode_d = pwdata[7:0];
		end
		if (wr_ctrl) begin
			ctrl_d = pwdata[5:0] & `MMT_CTRL_MASK;
			if (QUAD_KIND == MMT_QK_NONE) begin
				ctrl_d[`MMT_CTRL_QEN] = 1'b0;
			end
		end

		unique case (op)
			MMT_OP_EVENT: begin
				pulse_output_pin_oe = mode_q[`MMT_MODE_FB0] && !mode_q[`MMT_MODE_FB2]
					&& !quad_on;
				if (ev_step) begin
					cnt_d = ev_next;
					if (ev_wrap) begin
						irq_d = 1'b1;                                        // [RQ6]
						ovf_d = 1'b1;
						if (mode_q[`MMT_MODE_FB0]) begin
							out_d = !out_q;                                  // [RQ10]
						end
					end
				end
			end
			MMT_OP_ONESHOT: begin
				pulse_output_pin_oe = mode_q[`MMT_MODE_FB0];
				if (!start) begin
					os_run_d = 1'b0;                                         // [RQ19]
					out_d    = 1'b0;
				end else if (os_trig) begin
					cnt_d    = reload_q;                                     // [RQ18]
					os_run_d = 1'b1;
					out_d    = mode_q[`MMT_MODE_FB0];
				end else if (os_run_q && src_tick) begin
					if (cnt_q <= `MMT_CNT_ONE) begin
						cnt_d    = reload_q;                                 // [RQ17]
						os_run_d = 1'b0;
						out_d    = 1'b0;
						irq_d    = 1'b1;
						ovf_d    = 1'b1;
					end else begin
						cnt_d = cnt_q - `MMT_CNT_ONE;
					end
				end
			end
			MMT_OP_PWM: begin
				pulse_output_pin_oe = 1'b1;
				if (src_tick && pw_q != MMT_PW_IDLE) begin
					pre_d = (pre_q == `MMT_PRE_ZERO) ? reload_q[7:0] : pre_q - 8'h01;
				end
				if (!start) begin
					pw_d  = MMT_PW_IDLE;
					out_d = 1'b0;
				end else begin
					unique case (pw_q)
						MMT_PW_IDLE: begin
							if (!mode_q[`MMT_MODE_FB2] || trig) begin
								pre_d = reload_q[7:0];
								cnt_d = (hi_len != `MMT_CNT_ZERO) ? hi_len : lo_len;
								out_d = hi_len != `MMT_CNT_ZERO;
								pw_d  = (hi_len != `MMT_CNT_ZERO) ? MMT_PW_HIGH : MMT_PW_LOW;
							end
						end
						MMT_PW_HIGH: begin
							if (ptick && cnt_q <= `MMT_CNT_ONE) begin
								if (lo_len == `MMT_CNT_ZERO) begin
									cnt_d = hi_len;
								end else begin
									cnt_d = lo_len;
									out_d = 1'b0;
									irq_d = 1'b1;                            // [RQ20]
									pw_d  = MMT_PW_LOW;
								end
							end else if (ptick) begin
								cnt_d = cnt_q - `MMT_CNT_ONE;
							end
						end
						MMT_PW_LOW: begin
							if (ptick && cnt_q <= `MMT_CNT_ONE) begin
								ovf_d = 1'b1;
								cnt_d = (hi_len != `MMT_CNT_ZERO) ? hi_len : lo_len; // [RQ20]
								out_d = hi_len != `MMT_CNT_ZERO;
								pw_d  = (hi_len != `MMT_CNT_ZERO) ? MMT_PW_HIGH : MMT_PW_LOW;
							end else if (ptick) begin
								cnt_d = cnt_q - `MMT_CNT_ONE;
							end
						end
					endcase
				end
			end
			MMT_OP_TIMER: begin
				out_d = 1'b0;
			end
		endcase

		if (wr_timer) begin
			reload_d = pwdata[15:0];                                         // [RQ7]
			if (!start) begin
				cnt_d = pwdata[15:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mode_q   <= `MMT_RST_MODE;
			reload_q <= `MMT_RST_CNT;
			cnt_q    <= `MMT_RST_CNT;
			ctrl_q   <= `MMT_RST_CTRL;
			pre_q    <= `MMT_RST_PRE;
			out_q    <= 1'b0;
			os_run_q <= 1'b0;
			irq_q    <= 1'b0;
			ovf_q    <= 1'b0;
			pin_q    <= 1'b0;
			phb_q    <= 1'b0;
			pw_q     <= MMT_PW_IDLE;
		end else begin
			mode_q   <= mode_d;
			reload_q <= reload_d;
			cnt_q    <= cnt_d;
			ctrl_q   <= ctrl_d;
			pre_q    <= pre_d;
			out_q    <= out_d;
			os_run_q <= os_run_d;
			irq_q    <= irq_d;
			ovf_q    <= ovf_d;
			pin_q    <= pin_d;
			phb_q    <= phb_d;
			pw_q     <= pw_d;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	ev_reload_a: assert property ((ev_step && ev_wrap && !free_run && !wr_timer) // [RQ4]
		|=> cnt_q == $past(reload_q)) else $error("reload not taken on wrap");
	free_wrap_a: assert property ((ev_step && ev_wrap && free_run && !wr_timer) // [RQ9]
		|=> cnt_q == ($past(ev_up) ? `MMT_CNT_ZERO : `MMT_CNT_MAX))
		else $error("free-run wrap wrong");
	ev_irq_a: assert property ((ev_step && ev_wrap) |=> timer_irq && timer_ovf) // [RQ6]
		else $error("no irq on wrap");
	pulse_flip_a: assert property ((ev_step && ev_wrap && mode_q[`MMT_MODE_FB0]) // [RQ10]
		|=> pulse_output_pin_o != $past(pulse_output_pin_o)) else $error("no toggle");
	wr_stop_a: assert property ((wr_timer && !start) // [RQ7]
		|=> cnt_q == $past(pwdata[15:0]) && reload_q == cnt_q) else $error("stopped write");
	wr_run_a: assert property ((wr_timer && start && op == MMT_OP_EVENT && !ev_step) // [RQ7]
		|=> $stable(cnt_q) && reload_q == $past(pwdata[15:0])) else $error("running write");
	halt_a: assert property ((!start && op == MMT_OP_EVENT && !wr_timer) // [RQ8]
		|=> $stable(cnt_q)) else $error("counted while stopped");
	down_step_a: assert property ((ev_step && !ev_up && !ev_wrap && !quad_on // [RQ24]
		&& !mode_q[`MMT_MODE_FB2] && !wr_timer) |=> cnt_q == $past(cnt_q) - `MMT_CNT_ONE)
		else $error("down step wrong");
	os_end_a: assert property ((op == MMT_OP_ONESHOT && os_run_q && src_tick && !os_trig // [RQ17]
		&& start && cnt_q <= `MMT_CNT_ONE) |=> !os_run_q && timer_irq ##1 !timer_irq)
		else $error("one-shot end wrong");
	os_restart_a: assert property ((op == MMT_OP_ONESHOT && os_trig && !wr_timer) // [RQ18]
		|=> os_run_q && cnt_q == $past(reload_q)) else $error("one-shot restart");
	pwm_fall_a: assert property ((op == MMT_OP_PWM && $fell(pulse_output_pin_o) && start) // [RQ20]
		|-> timer_irq) else $error("no irq at pwm fall");
	quad_x4_a: assert property ((quad_on && quad_x4 && start && pin_rise // [RQ12]
		&& pulse_output_pin_i && !wr_timer && !ev_wrap) |=> cnt_q == $past(cnt_q) + `MMT_CNT_ONE)
		else $error("x4 up step wrong");
endmodule

// ### mmt_encoder_model.sv
// two-phase encoder feeding the timer channel pins
module mmt_encoder_model (
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic step_up,
	input  wire logic step_dn,
	output logic      phase_a,
	output logic      phase_b
);
	logic [1:0] pos_q;
	logic [1:0] pos_d;

	always_comb begin
		pos_d = pos_q;
		if (step_up)
			pos_d = pos_q + 2'h1;
		else if (step_dn)
			pos_d = pos_q - 2'h1;
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			pos_q <= 2'h0;
		else
			pos_q <= pos_d;
	end

	// gray order 00,01,11,10: going up, phase_a rises while phase_b is high
	assign phase_a = pos_q[1];
	assign phase_b = pos_q[1] ^ pos_q[0];
endmodule

// ### multi_mode_timer_channel_bench.sv
// self-checking bench of the timer channel
`include "mmt_cfg.svh"

module multi_mode_timer_channel_bench;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [11:0] A_MODE = `MMT_ADDR_MODE;
	localparam logic [11:0] A_TMR  = `MMT_ADDR_TIMER;
	localparam logic [11:0] A_CTRL = `MMT_ADDR_CTRL;
	localparam logic [11:0] A_STAT = `MMT_ADDR_STATUS;

	logic        core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr    = 12'h000;
	logic [31:0] pwdata   = 32'h0, prdata, rng_q = 32'h25;
	logic [8:0]  src_v    = 9'h000;
	logic        pready, pslverr, pin_o, pin_oe, timer_irq, t_ovf, phase_a, phase_b;
	wire logic   pin_i;
	logic [32:0] exp_q[$];
	int          n_errors = 0, total_checks = 0, n_irq = 0;

	assign pin_i = pin_oe ? pin_o : phase_b;

	always #10 core_clk = ~core_clk;

	mmt_channel #(.QUAD_KIND(mmt_pkg::MMT_QK_SELECT)) dut (
		.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tick_f1(src_v[0]), .tick_f8(src_v[1]),
		.tick_f32(src_v[2]), .tick_subclock_div32(src_v[3]), .ovf_in_a(src_v[4]),
		.ovf_in_b(src_v[5]), .ovf_in_c(src_v[6]), .count_input_pin(phase_a),
		.pulse_output_pin_i(pin_i), .pulse_output_pin_o(pin_o),
		.pulse_output_pin_oe(pin_oe), .timer_irq(timer_irq), .timer_ovf(t_ovf)
	);

	mmt_encoder_model enc (
		.core_clk(core_clk), .nrst(nrst), .step_up(src_v[7]), .step_dn(src_v[8]),
		.phase_a(phase_a), .phase_b(phase_b)
	);

	function automatic logic [31:0] xs();
		rng_q ^= rng_q << 13;
		rng_q ^= rng_q >> 17;
		rng_q ^= rng_q << 5;
		return rng_q;
	endfunction

	task automatic check(input string nm, input logic [32:0] e, input logic [32:0] s);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// expected {pslverr, prdata} is noted before the read
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic pulse(input logic [8:0] m, input int n);
		repeat (n) begin
			src_v <= m;
			@(posedge core_clk);
			src_v <= 9'h000;
			@(posedge core_clk);
		end
	endtask

	always @(posedge core_clk)
		if (psel && penable && pready === 1'b1 && !pwrite)
			check("read", exp_q.pop_front(), {pslverr, prdata});

	always @(posedge core_clk)
		if (timer_irq === 1'b1)
			n_irq++;

	initial begin
		repeat (80000) @(posedge core_clk);
		n_errors++;
		final_report();
	end

	initial begin
		logic [15:0] n;
		int          hi;
		int          ni;
		int          nv;
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		rd(A_CTRL, 33'h0);
		wr(A_MODE, 32'hFFFF_FFFF);
		rd(A_MODE, 33'hFF);
		wr(A_CTRL, 32'h3E);
		rd(A_CTRL, 33'h3C);
		rd(12'h010, 33'h1_0000_0000);
		wr(A_CTRL, 32'h0);
		$display("register test done");
		n = 16'(xs() % 4) + 16'h1;
		wr(A_TMR, {16'h0, n});
		rd(A_TMR, {17'h0, n});
		n_irq = 0;
		wr(A_MODE, 32'h0D);
		wr(A_CTRL, 32'h01);
		pulse(9'h080, 4 * n);
		rd(A_TMR, 33'h0);
		wr(A_TMR, 32'h7);
		rd(A_TMR, 33'h0);
		pulse(9'h080, 4);
		rd(A_TMR, 33'h7);
		check("irq", 33'h1, 33'(n_irq));
		check("out", 33'h1, {32'h0, pin_o});
		wr(A_CTRL, 32'h0);
		pulse(9'h080, 4);
		rd(A_TMR, 33'h7);
		$display("event reload test done");
		n_irq = 0;
		wr(A_MODE, 32'h41);
		wr(A_TMR, 32'hFFFE);
		wr(A_CTRL, 32'h15);
		pulse(9'h020, 1);
		rd(A_TMR, 33'hFFFE);
		pulse(9'h010, 2);
		rd(A_TMR, 33'h0);
		check("irq", 33'h1, 33'(n_irq));
		$display("free-run test done");
		wr(A_CTRL, 32'h0);
		wr(A_MODE, 32'hD1);
		wr(A_TMR, 32'h5);
		wr(A_CTRL, 32'h09);
		pulse(9'h080, 4);
		rd(A_TMR, 33'h9);
		pulse(9'h100, 2);
		rd(A_TMR, 33'h7);
		check("oe", 33'h0, {32'h0, pin_oe});
		wr(A_CTRL, 32'h0);
		wr(A_MODE, 32'h51);
		wr(A_TMR, 32'h5);
		wr(A_CTRL, 32'h09);
		pulse(9'h080, 4);
		rd(A_TMR, 33'h6);
		pulse(9'h100, 4);
		rd(A_TMR, 33'h5);
		$display("two-phase test done");
		// single-phase, direction taken from the pin level (phase_b)
		wr(A_CTRL, 32'h0);
		wr(A_MODE, 32'h11);
		wr(A_TMR, 32'h5);
		wr(A_CTRL, 32'h11);
		pulse(9'h010, 1);
		pulse(9'h080, 1);
		pulse(9'h010, 2);
		rd(A_TMR, 33'h4);
		$display("direction pin test done");
		n_irq = 0;
		wr(A_CTRL, 32'h0);
		wr(A_MODE, 32'h06);
		wr(A_TMR, 32'h3);
		wr(A_CTRL, 32'h1);
		wr(A_CTRL, 32'h3);
		rd(A_STAT, 33'h3);
		pulse(9'h001, 2);
		wr(A_CTRL, 32'h3);
		pulse(9'h001, 2);
		rd(A_STAT, 33'h3);
		pulse(9'h001, 1);
		rd(A_STAT, 33'h0);
		check("irq", 33'h1, 33'(n_irq));
		wr(A_CTRL, 32'h3);
		wr(A_CTRL, 32'h0);
		rd(A_STAT, 33'h0);
		$display("one-shot test done");
		wr(A_MODE, 32'h27);
		wr(A_TMR, 32'h0201);
		wr(A_CTRL, 32'h1);
		src_v <= 9'h001;
		repeat (1100) @(posedge core_clk);
		hi = 0;
		ni = 0;
		nv = 0;
		repeat (510) begin
			@(posedge core_clk);
			hi += int'(pin_o === 1'b1);
			ni += int'(timer_irq === 1'b1);
			nv += int'(t_ovf === 1'b1);
		end
		src_v <= 9'h000;
		check("high", 33'd4, 33'(hi));
		check("irq", 33'h1, 33'(ni));
		check("ovf", 33'h1, 33'(nv));
		$display("pwm test done");
		wr(A_CTRL, 32'h0);
		wr(A_MODE, 32'h07);
		wr(A_TMR, 32'h5);
		wr(A_CTRL, 32'h1);
		src_v <= 9'h001;
		hi = 0;
		ni = 0;
		// one full 16-bit cycle, then the next pulse must rise
		repeat (65535) begin
			@(posedge core_clk);
			hi += int'(pin_o === 1'b1);
			ni += int'(timer_irq === 1'b1);
		end
		@(posedge core_clk);
		src_v <= 9'h000;
		check("high16", 33'd5, 33'(hi));
		check("irq16", 33'h1, 33'(ni));
		check("rise16", 33'h3, {31'h0, pin_o, t_ovf});
		$display("16-bit pwm test done");
		final_report();
	end
endmodule
